// *** include/wic_pkg.sv ***
// Constants and types for the two-wire write controller of the LED driver.
// Assumes a 20 MHz system clock; every timing count is derived from it here.

package wic_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Bus times in ns; least times round up to whole cycles.
  localparam int unsigned F_SCL_MAX_KHZ = 400;
  localparam int unsigned T_SCL_MIN_NS  = 1_000_000 / F_SCL_MAX_KHZ;
  localparam int unsigned T_LOW_NS      = 1300;
  localparam int unsigned T_HIGH_NS     = 700;
  localparam int unsigned T_BUF_NS      = 1300;
  localparam int unsigned T_HD_STA_NS   = 600;
  localparam int unsigned T_SU_STO_NS   = 600;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned LOW_CYC    = ns_to_cyc(T_LOW_NS);
  localparam int unsigned HIGH_MIN   = ns_to_cyc(T_HIGH_NS);
  localparam int unsigned PER_CYC    = ns_to_cyc(T_SCL_MIN_NS);
  // High phase is stretched so that low plus high never beats the 400 kHz period.
  localparam int unsigned HIGH_CYC   = (PER_CYC - LOW_CYC > HIGH_MIN) ?
                                       PER_CYC - LOW_CYC : HIGH_MIN;
  localparam int unsigned BUF_CYC    = ns_to_cyc(T_BUF_NS);
  localparam int unsigned HD_STA_CYC = ns_to_cyc(T_HD_STA_NS);
  localparam int unsigned SU_STO_CYC = ns_to_cyc(T_SU_STO_NS);
  localparam int unsigned TMR_W      = 6;

  // Target address layout.
  localparam logic [4:0] ADDR_FIXED = 5'h0F;
  localparam logic       DIR_WRITE  = 1'h0;
  localparam int unsigned BYTE_ACK  = 8;

  // Target register offsets and frequency codes.
  localparam logic [7:0] REG_SHUTDOWN  = 8'h00;
  localparam logic [7:0] REG_PWM_FIRST = 8'h01;
  localparam logic [7:0] REG_UPDATE    = 8'h25;
  localparam logic [7:0] REG_LED_FIRST = 8'h26;
  localparam logic [7:0] REG_GLOBAL    = 8'h4A;
  localparam logic [7:0] REG_FREQ      = 8'h4B;
  localparam logic [7:0] REG_RESET     = 8'h4F;
  localparam logic [7:0] FREQ_2K9      = 8'h00;
  localparam logic [7:0] FREQ_21K6     = 8'h01;

  typedef enum logic [1:0] {
    WIC_STRAP_GND = 2'h0,
    WIC_STRAP_VCC = 2'h1,
    WIC_STRAP_SCL = 2'h2,
    WIC_STRAP_SDA = 2'h3
  } wic_strap_t;

  typedef enum logic [2:0] {
    WIC_IDLE      = 3'h0,
    WIC_START     = 3'h1,
    WIC_LOW       = 3'h3,
    WIC_HIGH      = 3'h2,
    WIC_STOP_LOW  = 3'h6,
    WIC_STOP_HIGH = 3'h7,
    WIC_BUF       = 3'h5
  } wic_state_t;

  typedef enum logic [1:0] {
    WIC_PH_ADDR = 2'h0,
    WIC_PH_REG  = 2'h1,
    WIC_PH_DATA = 2'h3
  } wic_phase_t;

endpackage : wic_pkg

// *** logic/wic_ctrl.sv ***
// Two-wire bus controller that writes register bytes into the LED driver.
// Assumes the data line has an external pull-up and that this controller is
// the only one on the bus; the serial clock is made here by a divider.

`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Data FIFO
// ---------------------------------------------------------------------------
module wic_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             rstn,      // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Write side offers a word.
  output logic                  in_ready,  // Room for a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  output logic                  out_valid, // A word is waiting.
  input  wire logic             out_ready, // Reader takes the word.
  output logic      [WIDTH-1:0] out_data   // Oldest word.
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             do_wr;
  logic             do_rd;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign do_wr    = in_valid & in_ready;
  assign do_rd    = out_valid & out_ready;
  assign cnt_d    = cnt_q + CW'(do_wr) - CW'(do_rd);
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (do_wr) wr_ptr_q <= ptr_inc(wr_ptr_q);
      if (do_rd) rd_ptr_q <= ptr_inc(rd_ptr_q);
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != CNT_FULL);
      out_valid <= (cnt_d != '0);
    end
  end

  // Storage needs no reset; only words marked valid are ever read.
  always_ff @(posedge clk) begin
    if (do_wr) mem_q[wr_ptr_q] <= in_data;
  end
endmodule // wic_fifo

// ---------------------------------------------------------------------------
// Bus controller
// ---------------------------------------------------------------------------
module wic_ctrl #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic               clk,          // System clock, 20 MHz.
  input  wire logic               rstn,         // Asynchronous reset, active low.
  input  wire logic               start_valid,  // Request a write burst.
  output logic                    start_ready,  // Controller idle, burst taken.
  input  wire wic_pkg::wic_strap_t start_strap, // How the target strap is wired.
  input  wire logic         [7:0] start_reg,    // First target register.
  input  wire logic         [7:0] start_len,    // Number of data bytes.
  input  wire logic               data_valid,   // Data byte offered.
  output logic                    data_ready,   // Data byte taken.
  input  wire logic         [7:0] data_byte,    // Data byte.
  output logic                    done,         // Burst finished, one pulse.
  output logic                    nack,         // With done: target refused.
  output logic                    busy,         // Burst in progress.
  output logic              [7:0] dev_ptr,      // Target pointer as tracked.
  input  wire logic               run_en,       // Keep the target powered up.
  output logic                    shutdown_n_pin, // Target shutdown, active low.
  output logic                    scl_o,        // Serial clock.
  input  wire logic               sda_i,        // Data line as seen on the pin.
  output logic                    sda_o,        // Data line drive level.
  output logic                    sda_oe        // High while pulling data low.
);
  import wic_pkg::*;

  // -------------------------------------------------------------------------
  // Strap decoding and input synchroniser
  // -------------------------------------------------------------------------
  function automatic logic [1:0] strap_bits(input wic_strap_t s);
    logic [1:0] b;
    b = 2'h0;
    unique case (s)
      WIC_STRAP_GND: b = 2'h0;
      WIC_STRAP_VCC: b = 2'h3;
      WIC_STRAP_SCL: b = 2'h1;
      WIC_STRAP_SDA: b = 2'h2;
    endcase
    return b;
  endfunction

  logic       sda_s1_q;
  logic       sda_s2_q;
  logic       sda_s3_q;
  logic       sda_s_q;
  logic       sda_agree;

  assign sda_agree = (sda_s2_q == sda_s3_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      sda_s_q  <= 1'b1;
    end else begin
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (sda_agree) sda_s_q <= sda_s3_q;
    end
  end

  // -------------------------------------------------------------------------
  // Data FIFO
  // -------------------------------------------------------------------------
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;

  wic_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (data_valid),
    .in_ready  (data_ready),
    .in_data   (data_byte),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // -------------------------------------------------------------------------
  // Sequencer state
  // -------------------------------------------------------------------------
  wic_state_t       state_q;
  wic_state_t       state_d;
  wic_phase_t       phase_q;
  wic_phase_t       phase_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_d;
  logic [3:0]       bit_q;
  logic [3:0]       bit_d;
  logic [7:0]       shreg_q;
  logic [7:0]       shreg_d;
  logic [7:0]       reg_q;
  logic [7:0]       len_q;
  logic [7:0]       len_d;
  logic [7:0]       ptr_d;
  logic             load_q;
  logic             load_d;
  logic             nack_d;
  logic             done_d;
  logic             scl_d;
  logic             sda_oe_d;

  logic             tmr_zero;
  logic             accept;
  logic             at_ack;
  logic             ack_seen;
  logic             waiting;

  assign tmr_zero = (tmr_q == '0);
  assign accept   = start_valid & start_ready;
  assign at_ack   = (bit_q == 4'(BYTE_ACK));
  assign ack_seen = ~sda_s_q;
  // A data slot with nothing to send holds the clock low until a byte arrives.
  assign waiting  = (state_q == WIC_LOW) & load_q & ~fifo_valid;
  assign fifo_pop = (state_q == WIC_LOW) & load_q & fifo_valid;

  always_comb begin
    state_d  = state_q;
    phase_d  = phase_q;
    tmr_d    = tmr_zero ? tmr_q : tmr_q - TMR_W'(1);
    bit_d    = bit_q;
    shreg_d  = shreg_q;
    len_d    = len_q;
    ptr_d    = dev_ptr;
    load_d   = load_q;
    nack_d   = nack;
    done_d   = 1'b0;
    scl_d    = scl_o;
    sda_oe_d = sda_oe;
    unique case (state_q)
      WIC_IDLE: begin
        scl_d    = 1'b1;
        sda_oe_d = 1'b0;
        if (accept) begin
          shreg_d  = {ADDR_FIXED, strap_bits(start_strap), DIR_WRITE};
          len_d    = start_len;
          phase_d  = WIC_PH_ADDR;
          nack_d   = 1'b0;
          sda_oe_d = 1'b1;
          tmr_d    = TMR_W'(HD_STA_CYC - 1);
          state_d  = WIC_START;
        end
      end
      WIC_START: begin
        if (tmr_zero) begin
          scl_d   = 1'b0;
          bit_d   = '0;
          load_d  = 1'b0;
          tmr_d   = TMR_W'(LOW_CYC - 1);
          state_d = WIC_LOW;
        end
      end
      WIC_LOW: begin
        if (fifo_pop) begin
          shreg_d = fifo_data;
          load_d  = 1'b0;
          tmr_d   = TMR_W'(LOW_CYC - 1);
        end else if (waiting) begin
          tmr_d = tmr_q;
        end else begin
          // The data line moves only while the clock is low.
          sda_oe_d = at_ack ? 1'b0 : ~shreg_q[7];
          if (tmr_zero) begin
            scl_d   = 1'b1;
            tmr_d   = TMR_W'(HIGH_CYC - 1);
            state_d = WIC_HIGH;
          end
        end
      end
      WIC_HIGH: begin
        if (tmr_zero) begin
          scl_d = 1'b0;
          tmr_d = TMR_W'(LOW_CYC - 1);
          if (!at_ack) begin
            shreg_d = {shreg_q[6:0], 1'b0};
            bit_d   = bit_q + 4'h1;
            state_d = WIC_LOW;
          end else if (!ack_seen) begin
            nack_d  = 1'b1;
            state_d = WIC_STOP_LOW;
          end else begin
            bit_d   = '0;
            state_d = WIC_LOW;
            unique case (phase_q)
              WIC_PH_ADDR: begin
                shreg_d = reg_q;
                phase_d = WIC_PH_REG;
              end
              WIC_PH_REG: begin
                ptr_d   = reg_q;
                phase_d = WIC_PH_DATA;
                load_d  = (len_q != '0);
                if (len_q == '0) state_d = WIC_STOP_LOW;
              end
              WIC_PH_DATA: begin
                ptr_d  = dev_ptr + 8'h01;
                len_d  = len_q - 8'h01;
                load_d = (len_q != 8'h01);
                if (len_q == 8'h01) state_d = WIC_STOP_LOW;
              end
              default: state_d = WIC_STOP_LOW;
            endcase
          end
        end
      end
      WIC_STOP_LOW: begin
        sda_oe_d = 1'b1;
        if (tmr_zero) begin
          scl_d   = 1'b1;
          tmr_d   = TMR_W'(SU_STO_CYC - 1);
          state_d = WIC_STOP_HIGH;
        end
      end
      WIC_STOP_HIGH: begin
        if (tmr_zero) begin
          sda_oe_d = 1'b0;
          tmr_d    = TMR_W'(BUF_CYC - 1);
          state_d  = WIC_BUF;
        end
      end
      WIC_BUF: begin
        if (tmr_zero) begin
          done_d  = 1'b1;
          state_d = WIC_IDLE;
        end
      end
      default: state_d = WIC_IDLE;
    endcase
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= WIC_IDLE;
      phase_q <= WIC_PH_ADDR;
      tmr_q   <= '0;
      bit_q   <= '0;
      shreg_q <= '0;
      len_q   <= '0;
      load_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      tmr_q   <= tmr_d;
      bit_q   <= bit_d;
      shreg_q <= shreg_d;
      len_q   <= len_d;
      load_q  <= load_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_q <= '0;
    end else if (accept) begin
      reg_q <= start_reg;
    end
  end

  // Repeated START is never issued; each burst closes with STOP first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_ready    <= 1'b0;
      done           <= 1'b0;
      nack           <= 1'b0;
      busy           <= 1'b0;
      dev_ptr        <= '0;
      shutdown_n_pin <= 1'b0;
      scl_o          <= 1'b1;
      sda_o          <= 1'b0;
      sda_oe         <= 1'b0;
    end else begin
      start_ready    <= (state_d == WIC_IDLE);
      done           <= done_d;
      nack           <= nack_d;
      busy           <= (state_d != WIC_IDLE);
      dev_ptr        <= ptr_d;
      shutdown_n_pin <= run_en;
      scl_o          <= scl_d;
      sda_o          <= 1'b0;
      sda_oe         <= sda_oe_d;
    end
  end
endmodule // wic_ctrl

`default_nettype wire

// *** sim/wic_ctrl_properties.sv ***
// Concurrent checks on the ports of the two-wire write controller.
// Assumes the bench binds it to wic_ctrl and the package is compiled first.
`timescale 1ns/1ps
`default_nettype none
module wic_ctrl_properties
  import wic_pkg::*;
(
  input wire logic clk,         // System clock.
  input wire logic rstn,        // Reset, active low.
  input wire logic start_valid, // Burst request.
  input wire logic start_ready, // Burst taken.
  input wire logic busy,        // Burst running.
  input wire logic done,        // End pulse.
  input wire logic nack,        // Refusal flag.
  input wire logic scl_o,       // Serial clock.
  input wire logic sda_i,       // Data line level.
  input wire logic sda_oe       // Data pulled low.
);
  // ---------------------------------------------------------------------
  // Bit tracking
  // ---------------------------------------------------------------------
  logic       scl_q, oe_q, first_q, ack_q;
  logic [3:0] cnt_q;
  logic [5:0] low_q, high_q;
  wire        rise    = scl_o & ~scl_q;
  wire        strt    = sda_oe & ~oe_q & scl_o & scl_q;
  wire        wrap    = rise & (cnt_q == 4'h8);
  wire [3:0]  cnt_d   = strt ? 4'h0 : wrap ? 4'h0 : rise ? cnt_q + 4'h1 : cnt_q;
  wire        first_d = strt | (first_q & ~wrap);
  wire        ack_d   = rise ? wrap : (ack_q & scl_o);
  // Counters saturate so a long idle high never wraps into a short one.
  wire [5:0]  low_d   = scl_o ? 6'h00 : low_q + {5'h00, ~&low_q};
  wire [5:0]  high_d  = scl_o ? high_q + {5'h00, ~&high_q} : 6'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {scl_q, oe_q, first_q, ack_q} <= 4'h8;
      {cnt_q, low_q, high_q} <= {4'h0, 6'h00, 6'h3F};
    end else begin
      {scl_q, oe_q, first_q, ack_q} <= {scl_o, sda_oe, first_d, ack_d};
      {cnt_q, low_q, high_q} <= {cnt_d, low_d, high_d};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_start_hold: assert property (strt |-> scl_o [*8] ##[1:20] !scl_o)
    else $error("start condition not held before clock fell");
  a_bit_hold: assert property (scl_o && scl_q && $changed(sda_oe) |-> strt or ##[24:30] done)
    else $error("data changed while clock high outside start or stop");
  a_idle_high: assert property (done |-> !sda_oe && scl_o && !$past(sda_oe, 20))
    else $error("bus not idle high at end of burst");
  a_low_min: assert property (rise |-> low_q >= 6'(LOW_CYC))
    else $error("clock low phase too short");
  a_high_min: assert property (scl_q && !scl_o |-> high_q >= 6'(HIGH_CYC))
    else $error("clock high phase too short");
  a_addr_fixed: assert property (rise && first_q && cnt_q < 4'h5 |-> sda_oe == (cnt_q == 4'h0))
    else $error("fixed address bits wrong");
  a_write_dir: assert property (rise && first_q && cnt_q == 4'h7 |-> sda_oe)
    else $error("direction bit not write");
  a_ack_free: assert property (rise && cnt_q == 4'h8 |-> !sda_oe [*8])
    else $error("data line not released in acknowledge slot");
  a_nack_stop: assert property ($rose(ack_q) && sda_i |->
    ##[40:80] ($fell(sda_oe) && scl_o) ##[20:40] (done && nack))
    else $error("missing acknowledge not ended by stop");

  c_good: cover property (done && !nack);
  c_refused: cover property (done && nack);
  c_blocked: cover property (start_valid && busy && !start_ready);
endmodule // wic_ctrl_properties
`default_nettype wire

// *** sim/wic_tgt_model.sv ***
// Behavioural model of the LED driver's write-only two-wire target.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module wic_tgt_model
  import wic_pkg::*;
(
  input  wire logic       scl,            // Serial clock.
  input  wire logic       sda,            // Resolved data line.
  input  wire logic [1:0] ad,             // Strap address bits.
  output logic            sda_pull,       // High while pulling data low.
  output logic            pwm_freq_select // Output frequency select.
);
  logic [7:0] mem [0:255];
  logic [7:0] sh  = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic       act = 1'b0;
  logic       ok  = 1'b0;
  int         bitn = 0;
  int         nbyte = 0;
  initial sda_pull = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  assign pwm_freq_select = mem[REG_FREQ][0];

  always @(negedge sda) if (scl) begin
    act = 1'b1;
    bitn = 0;
    nbyte = 0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    bitn = bitn + 1;
    if (bitn == 9) begin
      bitn = 0;
      if (!ok) act = 1'b0;
      else if (nbyte == 1) ptr = sh;
      else if (nbyte > 1) begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
      nbyte = nbyte + 1;
    end
  end
  always @(negedge scl) begin
    ok = act && bitn == 8 && (nbyte > 0 || sh == {5'h0F, ad, 1'b0});
    sda_pull = ok;
  end
endmodule // wic_tgt_model
`default_nettype wire

// *** sim/write_only_i2c_target_autoinc_bench.sv ***
// Self-checking bench: controller writing into the target model.
// Assumes package, controller, target model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module write_only_i2c_target_autoinc_bench;
  import wic_pkg::*;
  typedef struct packed {logic nk; logic [7:0] ptr;} wic_exp_t;
  logic       clk = 1'b0, rstn = 1'b0, start_valid = 1'b0, data_valid = 1'b0, run_en = 1'b1;
  wic_strap_t strap = WIC_STRAP_GND;
  logic [7:0] start_reg = 8'h00, start_len = 8'h00, data_byte = 8'h00, last_ptr = 8'h00;
  logic [7:0] dev_ptr;
  logic [8:0] pin = 9'h000;
  logic [1:0] tgt_ad = 2'h0;
  logic       start_ready, data_ready, done, nack, busy, shutdown_n_pin;
  logic       scl_o, sda_o, sda_oe, pull, freq_sel;
  wire        sda = pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  wic_exp_t   exp_q[$];
  wic_exp_t   mon;
  int         bad_count = 0, compares = 0;

  wic_ctrl #(.FIFO_DEPTH(8)) uut (.clk(clk), .rstn(rstn), .start_valid(start_valid),
    .start_ready(start_ready), .start_strap(strap), .start_reg(start_reg),
    .start_len(start_len), .data_valid(data_valid), .data_ready(data_ready),
    .data_byte(data_byte), .done(done), .nack(nack), .busy(busy), .dev_ptr(dev_ptr),
    .run_en(run_en), .shutdown_n_pin(shutdown_n_pin), .scl_o(scl_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  wic_tgt_model tgt (.scl(scl_o), .sda(sda), .ad(tgt_ad), .sda_pull(pull),
    .pwm_freq_select(freq_sel));

  initial forever #25 clk = ~clk;

  function automatic logic [1:0] ad_of(input wic_strap_t s);
    return (s == WIC_STRAP_VCC) ? 2'h3 : (s == WIC_STRAP_SCL) ? 2'h1 :
           (s == WIC_STRAP_SDA) ? 2'h2 : 2'h0;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A stalled handshake is cut short and counted rather than hanging the run.
  task automatic await(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig !== 1'b1 && n < 40000);
    if (sig !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic push(input logic [7:0] d[$]);
    foreach (d[i]) begin
      data_valid <= 1'b1;
      data_byte <= d[i];
      await(data_ready);
    end
    data_valid <= 1'b0;
  endtask
  task automatic burst(input wic_strap_t s, input logic [7:0] r, input int len,
                       input logic nk, input int stall);
    logic [7:0] d[$];
    wic_exp_t   e;
    for (int i = 0; i < len; i++) d.push_back(pin[8] ? pin[7:0] : 8'($urandom));
    e = '{nk, nk ? last_ptr : r + 8'(len)};
    exp_q.push_back(e);
    if (stall == 0) push(d);
    if (len == 8) begin
      @(posedge clk);
      check({7'h00, data_ready}, 8'h00);
    end
    start_valid <= 1'b1;
    strap <= s;
    start_reg <= r;
    start_len <= 8'(len);
    await(start_ready);
    start_valid <= 1'b0;
    @(posedge clk);
    check({7'h00, busy}, 8'h01);
    if (stall != 0) begin
      repeat (stall) @(posedge clk);
      push(d);
    end
    await(done);
    foreach (d[i]) check(tgt.mem[r + 8'(i)], d[i]);
    last_ptr = e.ptr;
  endtask

  always @(posedge clk) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      mon = exp_q.pop_front();
      check({7'h00, nack}, {7'h00, mon.nk});
      check(dev_ptr, mon.ptr);
      check({6'h00, busy, sda_o}, 8'h00);
    end
  end

  initial begin
    void'($urandom(32'h08d34d13));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      tgt_ad <= ad_of(wic_strap_t'(k));
      burst(wic_strap_t'(k), 8'($urandom), 1 + int'($urandom % 3), 1'b0, 0);
    end
    tgt_ad <= ad_of(WIC_STRAP_VCC);
    burst(WIC_STRAP_VCC, 8'($urandom), 0, 1'b0, 0);
    burst(WIC_STRAP_VCC, REG_PWM_FIRST, 8, 1'b0, 0);
    burst(WIC_STRAP_VCC, 8'($urandom), 2, 1'b0, 1200);
    burst(WIC_STRAP_SDA, 8'($urandom), 0, 1'b1, 0);
    for (int k = 1; k >= 0; k--) begin
      pin = {1'b1, (k == 1) ? FREQ_21K6 : FREQ_2K9};
      burst(WIC_STRAP_VCC, REG_FREQ, 1, 1'b0, 0);
      check({7'h00, freq_sel}, 8'(k));
    end
    run_en <= 1'b0;
    repeat (2) @(posedge clk);
    check({7'h00, shutdown_n_pin}, 8'h00);
    run_en <= 1'b1;
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule // write_only_i2c_target_autoinc_bench

bind wic_ctrl wic_ctrl_properties u_props (.clk(clk), .rstn(rstn),
  .start_valid(start_valid), .start_ready(start_ready), .busy(busy), .done(done),
  .nack(nack), .scl_o(scl_o), .sda_i(sda_i), .sda_oe(sda_oe));
`default_nettype wire
